// ===== shared/swr_pkg.sv
// package: register map, fields, reset values and types of the standard wave run control
package swr_pkg;

    // ****************************************
    // register offsets (byte addresses)
    // ****************************************
    localparam logic [11:0] CTRL_OFS    = 12'h000;
    localparam logic [11:0] LOOPS_OFS   = 12'h004;
    localparam logic [11:0] PHASE_OFS   = 12'h008;
    localparam logic [11:0] SINC_OFS    = 12'h00c;
    localparam logic [11:0] EXPO_OFS    = 12'h010;
    localparam logic [11:0] CMD_OFS     = 12'h014;
    localparam logic [11:0] STATUS_OFS  = 12'h018;

    // ****************************************
    // control and command field positions
    // ****************************************
    localparam int CTRL_RUN_LSB   = 0;
    localparam int CTRL_ARM_BIT   = 2;
    localparam int CTRL_ENS_LSB   = 3;
    localparam int CTRL_ABS_BIT   = 5;
    localparam int CTRL_INS_LSB   = 6;
    localparam int CTRL_WAV_LSB   = 8;
    localparam int CTRL_OUT_BIT   = 12;

    localparam int CMD_ENABLE_BIT   = 0;
    localparam int CMD_ABORT_BIT    = 1;
    localparam int CMD_INITIATE_BIT = 2;

    // ****************************************
    // reset values and limits
    // ****************************************
    localparam logic [31:0] CTRL_RST   = 32'h0000_1000;
    localparam logic [19:0] LOOPS_RST  = 20'h00001;
    localparam logic [8:0]  PHASE_RST  = 9'h000;
    localparam logic [7:0]  SINC_RST   = 8'h04;
    localparam logic [7:0]  EXPO_RST   = 8'h01;
    localparam logic [19:0] LOOPS_MAX  = 20'hf4240;
    localparam logic [8:0]  PHASE_FULL = 9'h168;
    localparam logic [15:0] LFSR_SEED  = 16'hace1;

    typedef enum logic [1:0] {
        SWR_RUN_CONT = 2'b00,
        SWR_RUN_TRIG = 2'b01,
        SWR_RUN_GATE = 2'b10
    } swr_run_type;

    typedef enum logic [1:0] {
        SWR_SRC_BUS   = 2'b00,
        SWR_SRC_EVENT = 2'b01,
        SWR_SRC_TRIG  = 2'b10,
        SWR_SRC_FP    = 2'b11
    } swr_src_type;

    typedef enum logic [3:0] {
        SWR_WAV_SINE  = 4'h0,
        SWR_WAV_TRI   = 4'h1,
        SWR_WAV_SQR   = 4'h2,
        SWR_WAV_RAMP  = 4'h3,
        SWR_WAV_SINC  = 4'h4,
        SWR_WAV_GAUSS = 4'h5,
        SWR_WAV_EXP   = 4'h6,
        SWR_WAV_DC    = 4'h7,
        SWR_WAV_NOISE = 4'h8
    } swr_wave_type;

    typedef enum logic [2:0] {
        SWR_ST_IDLE  = 3'b000,
        SWR_ST_ARMED = 3'b001,
        SWR_ST_PLAY  = 3'b010,
        SWR_ST_CALC  = 3'b011
    } swr_state_type;

    typedef struct packed {
        logic         active;
        logic         idle_level;
        logic         recompute;
        logic         invert;
        logic         noise_on;
        logic         restart;
        logic         fp_lockout;
        logic [8:0]   start_phase;
        logic [7:0]   sinc_cycles;
        logic [3:0]   wave_sel;
    } swr_gen_ctl_type;

endpackage : swr_pkg

// ===== verilog/swr_run_ctrl.sv
// run mode, arming, abort and loop control for built-in standard waveforms
//
// Our own choices: register access over APB and the address map.
`timescale 1ns/100ps
// ****************************************
// Overview of operation
// - continuous mode plays the waveform without pause and needs no initiate event
// - triggered mode holds output until initiate, then plays the programmed loop count and waits again
// - gated mode plays only while the gate input is asserted
// - self-armed configuration starts generation without any enable signal
// - armed configuration waits for an enable from the selected enable source
// - before start the output holds idle level, the first waveform sample
// - the enable signal is ignored unless arm option is armed
// - enable source is remote command, event transition or trigger pulse
// - remote abort stops all output, ignored while self-armed
// - front-panel abort button halts output when selected as abort source
// - initiate source selection starts playout only in triggered mode; gated mode follows the gate pin
// - remote initiate source locks out front-panel operation
// - initiate source is front panel, remote, trigger pulse or event transition
// - each triggered initiate replays the waveform one to one million times
// - sinc spans programmable zero-crossing count, default four; a change during playout forces recompute
// - negative exponent factor produces the inverted exponential shape
// - noise replays a fixed pseudo-random record cyclically until turned off
// - triggered sine and triangle start each playout at programmed start phase
// ****************************************
module swr_run_ctrl #(
    parameter int NOISE_LEN = 1024
) (
    input  wire logic                 clk_i,
    input  wire logic                 sys_rst_i,
    input  wire logic                 psel_i,
    input  wire logic                 penable_i,
    input  wire logic                 pwrite_i,
    input  wire logic [11:0]          paddr_i,
    input  wire logic [31:0]          pwdata_i,
    output logic      [31:0]          prdata_o,
    output logic                      pready_o,
    output logic                      pslverr_o,
    input  wire logic                 trig_i,
    input  wire logic                 event_i,
    input  wire logic                 gate_i,
    input  wire logic                 fp_initiate_i,
    input  wire logic                 fp_abort_i,
    input  wire logic                 wave_end_i,
    input  wire logic                 calc_done_i,
    output swr_pkg::swr_gen_ctl_type  gen_ctl_o,
    output logic      [15:0]          noise_o
);

    // ****************************************
    // pin synchronisers and edge detect
    // ****************************************
    logic [4:0] sync1_ff;
    logic [4:0] sync2_ff;
    logic [4:0] prev_ff;
    logic [4:0] rise;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sync1_ff <= 5'h00;
            sync2_ff <= 5'h00;
            prev_ff  <= 5'h00;
        end else begin
            sync1_ff <= {fp_abort_i, fp_initiate_i, gate_i, event_i, trig_i};
            sync2_ff <= sync1_ff;
            prev_ff  <= sync2_ff;
        end
    end

    assign rise = sync2_ff & ~prev_ff;

    logic trig_p;
    logic event_p;
    logic gate_lvl;
    logic fpi_p;
    logic fpa_p;
    assign trig_p   = rise[0];
    assign event_p  = sync2_ff[1] ^ prev_ff[1];
    assign gate_lvl = sync2_ff[2];
    assign fpi_p    = rise[3];
    assign fpa_p    = rise[4];

    // ****************************************
    // registers
    // ****************************************
    logic [31:0] ctrl_ff;
    logic [19:0] loops_ff;
    logic [8:0]  phase_ff;
    logic [7:0]  sinc_ff;
    logic [7:0]  expo_ff;
    logic        wr_en;
    logic        rd_en;
    logic        cmd_en;
    logic        cmd_ab;
    logic        cmd_in;
    logic        sinc_chg;

    assign wr_en  = psel_i & penable_i & pwrite_i;
    assign rd_en  = psel_i & penable_i & ~pwrite_i;
    assign cmd_en = wr_en & (paddr_i == swr_pkg::CMD_OFS) & pwdata_i[swr_pkg::CMD_ENABLE_BIT];
    assign cmd_ab = wr_en & (paddr_i == swr_pkg::CMD_OFS) & pwdata_i[swr_pkg::CMD_ABORT_BIT];
    assign cmd_in = wr_en & (paddr_i == swr_pkg::CMD_OFS) & pwdata_i[swr_pkg::CMD_INITIATE_BIT];
    assign sinc_chg = wr_en & (paddr_i == swr_pkg::SINC_OFS) & (pwdata_i[7:0] != sinc_ff);

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ctrl_ff  <= swr_pkg::CTRL_RST;
            loops_ff <= swr_pkg::LOOPS_RST;
            phase_ff <= swr_pkg::PHASE_RST;
            sinc_ff  <= swr_pkg::SINC_RST;
            expo_ff  <= swr_pkg::EXPO_RST;
        end else if (wr_en) begin
            case (paddr_i)
                swr_pkg::CTRL_OFS:  ctrl_ff <= {19'h0, pwdata_i[12:0]};
                swr_pkg::LOOPS_OFS: begin
                    // out-of-range counts clamp so a zero never stalls playback
                    if (pwdata_i[19:0] == 20'h0)
                        loops_ff <= 20'h00001;
                    else if (pwdata_i[19:0] > swr_pkg::LOOPS_MAX)
                        loops_ff <= swr_pkg::LOOPS_MAX;
                    else
                        loops_ff <= pwdata_i[19:0];
                end
                swr_pkg::PHASE_OFS: begin
                    if (pwdata_i[8:0] < swr_pkg::PHASE_FULL)
                        phase_ff <= pwdata_i[8:0];
                end
                swr_pkg::SINC_OFS:  sinc_ff <= pwdata_i[7:0];
                swr_pkg::EXPO_OFS:  expo_ff <= pwdata_i[7:0];
                default: ;
            endcase
        end
    end

    swr_pkg::swr_run_type run_mode;
    logic                 armed_cfg;
    swr_pkg::swr_src_type en_src;
    logic                 ab_fp;
    swr_pkg::swr_src_type in_src;
    logic [3:0]           wave_sel;
    logic                 out_on;
    assign run_mode  = swr_pkg::swr_run_type'(ctrl_ff[swr_pkg::CTRL_RUN_LSB +: 2]);
    assign armed_cfg = ctrl_ff[swr_pkg::CTRL_ARM_BIT];
    assign en_src    = swr_pkg::swr_src_type'(ctrl_ff[swr_pkg::CTRL_ENS_LSB +: 2]);
    assign ab_fp     = ctrl_ff[swr_pkg::CTRL_ABS_BIT];
    assign in_src    = swr_pkg::swr_src_type'(ctrl_ff[swr_pkg::CTRL_INS_LSB +: 2]);
    assign wave_sel  = ctrl_ff[swr_pkg::CTRL_WAV_LSB +: 4];
    assign out_on    = ctrl_ff[swr_pkg::CTRL_OUT_BIT];

    // ****************************************
    // event qualification
    // ****************************************
    function automatic logic src_hit(input swr_pkg::swr_src_type s, input logic bus,
                                     input logic ev, input logic tr, input logic fp);
        case (s)
            swr_pkg::SWR_SRC_BUS:   src_hit = bus;
            swr_pkg::SWR_SRC_EVENT: src_hit = ev;
            swr_pkg::SWR_SRC_TRIG:  src_hit = tr;
            default:                src_hit = fp;
        endcase
    endfunction : src_hit

    logic fp_lock;
    logic en_hit;
    logic in_hit;
    logic abort_hit;
    assign fp_lock = (in_src == swr_pkg::SWR_SRC_BUS);
    // enable has no front-panel source; fp code reads as never
    assign en_hit  = armed_cfg & src_hit(en_src, cmd_en, event_p, trig_p, 1'b0);
    assign in_hit  = src_hit(in_src, cmd_in, event_p, trig_p, fpi_p & ~fp_lock);
    assign abort_hit = (ab_fp ? (fpa_p & ~fp_lock) : (cmd_ab & armed_cfg))
                       | ~out_on;

    // ****************************************
    // run state machine
    // ****************************************
    swr_pkg::swr_state_type state_ff;
    swr_pkg::swr_state_type nxt_state;
    logic [19:0]            loop_cnt_ff;
    logic                   playing;
    logic                   gate_ok;

    // gate input acts as gate only in gated mode; a gate-source choice is the gate pin
    assign gate_ok = gate_lvl;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            swr_pkg::SWR_ST_IDLE: begin
                if (!abort_hit) begin
                    if (!armed_cfg || en_hit)
                        nxt_state = swr_pkg::SWR_ST_ARMED;
                end
            end
            swr_pkg::SWR_ST_ARMED: begin
                if (abort_hit)
                    nxt_state = swr_pkg::SWR_ST_IDLE;
                else if (run_mode == swr_pkg::SWR_RUN_CONT)
                    nxt_state = swr_pkg::SWR_ST_PLAY;
                else if (run_mode == swr_pkg::SWR_RUN_TRIG && in_hit)
                    nxt_state = swr_pkg::SWR_ST_PLAY;
                else if (run_mode == swr_pkg::SWR_RUN_GATE && gate_ok)
                    nxt_state = swr_pkg::SWR_ST_PLAY;
            end
            swr_pkg::SWR_ST_PLAY: begin
                if (abort_hit)
                    nxt_state = swr_pkg::SWR_ST_IDLE;
                else if (sinc_chg && wave_sel == swr_pkg::SWR_WAV_SINC)
                    nxt_state = swr_pkg::SWR_ST_CALC;
                else if (run_mode == swr_pkg::SWR_RUN_GATE && !gate_ok)
                    nxt_state = swr_pkg::SWR_ST_ARMED;
                else if (run_mode == swr_pkg::SWR_RUN_TRIG && wave_end_i
                         && loop_cnt_ff == 20'h00001)
                    nxt_state = swr_pkg::SWR_ST_ARMED;
            end
            swr_pkg::SWR_ST_CALC: begin
                if (abort_hit)
                    nxt_state = swr_pkg::SWR_ST_IDLE;
                else if (calc_done_i)
                    nxt_state = swr_pkg::SWR_ST_ARMED;
            end
            default: nxt_state = swr_pkg::SWR_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i)
            state_ff <= swr_pkg::SWR_ST_IDLE;
        else
            state_ff <= nxt_state;
    end

    assign playing = (state_ff == swr_pkg::SWR_ST_PLAY);

    // loop counter reloads on each start of playout
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i)
            loop_cnt_ff <= swr_pkg::LOOPS_RST;
        else if (nxt_state == swr_pkg::SWR_ST_PLAY && !playing)
            loop_cnt_ff <= loops_ff;
        else if (playing && wave_end_i && loop_cnt_ff != 20'h00001)
            loop_cnt_ff <= loop_cnt_ff - 20'h00001;
    end

    // ****************************************
    // generator controls
    // ****************************************
    logic restart_ff;
    logic recompute_ff;
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            restart_ff   <= 1'b0;
            recompute_ff <= 1'b0;
        end else begin
            restart_ff   <= (nxt_state == swr_pkg::SWR_ST_PLAY) && !playing;
            // one pulse per entry, so the generator starts a single recompute
            recompute_ff <= (nxt_state == swr_pkg::SWR_ST_CALC)
                            && (state_ff != swr_pkg::SWR_ST_CALC);
        end
    end

    logic phase_use;
    assign phase_use = (run_mode == swr_pkg::SWR_RUN_TRIG)
                       && (wave_sel == swr_pkg::SWR_WAV_SINE || wave_sel == swr_pkg::SWR_WAV_TRI);

    always_comb begin
        gen_ctl_o             = '0;
        gen_ctl_o.active      = playing;
        gen_ctl_o.idle_level  = ~playing;
        gen_ctl_o.recompute   = recompute_ff;
        gen_ctl_o.invert      = (wave_sel == swr_pkg::SWR_WAV_EXP) & expo_ff[7];
        gen_ctl_o.noise_on    = playing & (wave_sel == swr_pkg::SWR_WAV_NOISE);
        gen_ctl_o.restart     = restart_ff;
        gen_ctl_o.fp_lockout  = fp_lock;
        gen_ctl_o.start_phase = phase_use ? phase_ff : 9'h000;
        gen_ctl_o.sinc_cycles = sinc_ff;
        gen_ctl_o.wave_sel    = wave_sel;
    end

    // ****************************************
    // noise record
    // ****************************************
    // record is regenerated from a fixed seed, so every lap is identical
    localparam int NIDX_W = $clog2(NOISE_LEN);
    logic [15:0]       lfsr_ff;
    logic [NIDX_W-1:0] nidx_ff;
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            lfsr_ff <= swr_pkg::LFSR_SEED;
            nidx_ff <= '0;
            noise_o <= 16'h0000;
        end else if (!gen_ctl_o.noise_on || nidx_ff == NIDX_W'(NOISE_LEN - 1)) begin
            lfsr_ff <= swr_pkg::LFSR_SEED;
            nidx_ff <= '0;
            noise_o <= gen_ctl_o.noise_on ? lfsr_ff : 16'h0000;
        end else begin
            lfsr_ff <= {lfsr_ff[14:0], lfsr_ff[15] ^ lfsr_ff[13] ^ lfsr_ff[12] ^ lfsr_ff[10]};
            nidx_ff <= nidx_ff + 1'b1;
            noise_o <= lfsr_ff;
        end
    end

    // ****************************************
    // read path
    // ****************************************
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i)
            prdata_o <= 32'h0000_0000;
        else if (psel_i && !penable_i && !pwrite_i) begin
            case (paddr_i)
                swr_pkg::CTRL_OFS:   prdata_o <= ctrl_ff;
                swr_pkg::LOOPS_OFS:  prdata_o <= {12'h000, loops_ff};
                swr_pkg::PHASE_OFS:  prdata_o <= {23'h0, phase_ff};
                swr_pkg::SINC_OFS:   prdata_o <= {24'h0, sinc_ff};
                swr_pkg::EXPO_OFS:   prdata_o <= {24'h0, expo_ff};
                swr_pkg::STATUS_OFS: prdata_o <= {8'h0, loop_cnt_ff, fp_lock, state_ff};
                default:             prdata_o <= 32'h0000_0000;
            endcase
        end
    end

    logic addr_ok;
    assign addr_ok = (paddr_i[1:0] == 2'b00) && (paddr_i <= swr_pkg::STATUS_OFS);
    assign pready_o  = 1'b1;
    assign pslverr_o = psel_i & penable_i & ~addr_ok;

endmodule : swr_run_ctrl

// ===== dv/swr_run_ctrl_checker.sv
// assertion checker bound to the run control ports
`timescale 1ns/100ps
module swr_run_ctrl_checker (
    input wire logic                     clk_i,
    input wire logic                     sys_rst_i,
    input wire logic                     psel_i,
    input wire logic                     penable_i,
    input wire logic                     pwrite_i,
    input wire logic [11:0]              paddr_i,
    input wire logic [31:0]              pwdata_i,
    input wire swr_pkg::swr_gen_ctl_type gen_ctl_o,
    input wire logic [15:0]              noise_o
);
    // ****************************************
    // port properties
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    logic wr_ctrl;
    assign wr_ctrl = psel_i && penable_i && pwrite_i && paddr_i == swr_pkg::CTRL_OFS;
    property p_idle;
        gen_ctl_o.idle_level == !gen_ctl_o.active;
    endproperty
    a_idle: assert property (p_idle) else $error("idle level wrong");
    property p_phase;
        gen_ctl_o.start_phase != 9'h0 |-> gen_ctl_o.wave_sel[3:1] == 3'h0;
    endproperty
    a_phase: assert property (p_phase) else $error("start phase on wrong wave");
    property p_inv;
        gen_ctl_o.invert |-> gen_ctl_o.wave_sel == swr_pkg::SWR_WAV_EXP;
    endproperty
    a_inv: assert property (p_inv) else $error("invert on wrong wave");
    property p_non;
        gen_ctl_o.noise_on |-> gen_ctl_o.wave_sel == swr_pkg::SWR_WAV_NOISE;
    endproperty
    a_non: assert property (p_non) else $error("noise on wrong wave");
    property p_nzero;
        !gen_ctl_o.noise_on [*2] |-> noise_o == 16'h0;
    endproperty
    a_nzero: assert property (p_nzero) else $error("noise while off");
    property p_recomp;
        gen_ctl_o.recompute |-> !gen_ctl_o.active ##1 !gen_ctl_o.recompute;
    endproperty
    a_recomp: assert property (p_recomp) else $error("recompute while playing");
    property p_off;
        wr_ctrl && !pwdata_i[12] |=> ##1 !gen_ctl_o.active [*2];
    endproperty
    a_off: assert property (p_off) else $error("output off kept playing");
    property p_lock;
        !wr_ctrl |=> $stable(gen_ctl_o.fp_lockout);
    endproperty
    a_lock: assert property (p_lock) else $error("lockout moved");
    property p_rst;
        gen_ctl_o.restart == $rose(gen_ctl_o.active);
    endproperty
    a_rst: assert property (p_rst) else $error("restart pulse misplaced");
    c_play: cover property ($rose(gen_ctl_o.active));
    c_calc: cover property (gen_ctl_o.recompute);
    c_noise: cover property (gen_ctl_o.noise_on);
endmodule : swr_run_ctrl_checker

bind swr_run_ctrl swr_run_ctrl_checker u_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .gen_ctl_o(gen_ctl_o), .noise_o(noise_o));

// ===== dv/swr_far_end.sv
// far-side model: trigger, event, gate and panel pins plus generator feedback
`timescale 1ns/100ps
module swr_far_end (
    input  wire logic clk_i,
    input  wire logic sys_rst_i,
    input  wire logic active_i,
    input  wire logic recompute_i,
    output logic      trig_o,
    output logic      event_o,
    output logic      gate_o,
    output logic      fpi_o,
    output logic      fpa_o,
    output logic      wave_end_o,
    output logic      calc_done_o
);
    // ****************************************
    // pins and generator
    // ****************************************
    logic [2:0] cnt_ff;
    logic [3:0] cd_ff;
    initial {trig_o, event_o, gate_o, fpi_o, fpa_o} = 5'h00;
    // held three cycles so the two-stage sync cannot miss a pulse
    task automatic pin(input int k);
        case (k)
            1: event_o <= ~event_o;
            2: trig_o <= 1'b1;
            3: fpi_o <= 1'b1;
            4: fpa_o <= 1'b1;
            default: gate_o <= (k == 5);
        endcase
        repeat (3) @(posedge clk_i);
        {trig_o, fpi_o, fpa_o} <= 3'h0;
        @(posedge clk_i);
    endtask : pin
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_ff <= 3'h0;
            cd_ff <= 4'h0;
        end else begin
            cnt_ff <= active_i ? cnt_ff + 3'h1 : 3'h0;
            cd_ff <= {cd_ff[2:0], recompute_i};
        end
    end
    // period ends every 8 playing cycles; recompute answered 4 cycles later
    assign wave_end_o = active_i && (cnt_ff == 3'h7);
    assign calc_done_o = cd_ff[3];
endmodule : swr_far_end

// ===== dv/swr_run_ctrl_test.sv
// self-checking bench for the standard wave run control
`timescale 1ns/100ps
module swr_run_ctrl_test;
    logic                     clk, rst, psel, pen, pwr, pready, pslverr, serr;
    logic                     trig, ev, gate, fpi, fpa, wend, cdone;
    logic [11:0]              paddr;
    logic [31:0]              pwdata, prdata, rq;
    logic [15:0]              noise;
    logic [15:0]              smp [32];
    swr_pkg::swr_gen_ctl_type gc;
    int                       mismatches, checks_done, n;
    swr_run_ctrl #(.NOISE_LEN(16)) DUT (.clk_i(clk), .sys_rst_i(rst), .psel_i(psel),
        .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .trig_i(trig),
        .event_i(ev), .gate_i(gate), .fp_initiate_i(fpi), .fp_abort_i(fpa),
        .wave_end_i(wend), .calc_done_i(cdone), .gen_ctl_o(gc), .noise_o(noise));
    swr_far_end far (.clk_i(clk), .sys_rst_i(rst), .active_i(gc.active),
        .recompute_i(gc.recompute), .trig_o(trig), .event_o(ev), .gate_o(gate),
        .fpi_o(fpi), .fpa_o(fpa), .wave_end_o(wend), .calc_done_o(cdone));
    // ****************************************
    // tasks
    // ****************************************
    task automatic finish_test();
        $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        {psel, pwr, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge clk);
        pen <= 1'b1;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (pready !== 1'b1) begin
            mismatches++;
            finish_test();
        end
        rq = prdata;
        serr = pslverr;
        {psel, pen} <= 2'b00;
        @(posedge clk);
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rq, e);
    endtask : rdc
    task automatic wait_act(input logic v, input int m);
        for (int i = 0; i < m && gc.active !== v; i++) @(posedge clk);
        chk(32'(gc.active), 32'(v));
    endtask : wait_act
    task automatic fire(input int k, input logic [31:0] c);
        if (k == 0) wr(swr_pkg::CMD_OFS, c);
        else far.pin(k);
    endtask : fire
    task automatic cfg(input int r, input int a, input int en, input int ab, input int in,
                       input int wv);
        wr(swr_pkg::CTRL_OFS, 32'h0);
        @(posedge clk);
        chk(32'(gc.idle_level), 32'h1);
        wr(swr_pkg::CTRL_OFS, 32'h1000 | r | a << 2 | en << 3 | ab << 5 | in << 6 | wv << 8);
    endtask : cfg
    task automatic hold_chk(input logic [31:0] e);
        repeat (4) @(posedge clk);
        chk(32'(gc.active), e);
    endtask : hold_chk
    // ****************************************
    // sequence
    // ****************************************
    initial begin
        repeat (100000) @(posedge clk);
        mismatches++;
        finish_test();
    end
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        {rst, psel, pen, pwr, paddr, pwdata} = {1'b1, 3'h0, 12'h0, 32'h0};
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rdc(swr_pkg::CTRL_OFS, swr_pkg::CTRL_RST);
        rdc(swr_pkg::SINC_OFS, 32'h4);
        chk(32'(gc.fp_lockout), 32'h1);
        wait_act(1'b1, 10);
        wr(swr_pkg::CMD_OFS, 32'h2);
        hold_chk(32'h1);
        rdc(12'h040, 32'h0);
        chk(32'(serr), 32'h1);
        for (int s = 0; s < 3; s++) begin
            cfg(0, 1, s, 0, 0, 0);
            fire((s + 1) % 3, 32'h1);
            hold_chk(32'h0);
            fire(s, 32'h1);
            wait_act(1'b1, 10);
        end
        wr(swr_pkg::CMD_OFS, 32'h2);
        wait_act(1'b0, 4);
        hold_chk(32'h0);
        fire(2, 32'h0);
        wait_act(1'b1, 10);
        cfg(0, 0, 0, 1, 2, 0);
        wait_act(1'b1, 10);
        chk(32'(gc.fp_lockout), 32'h0);
        far.pin(4);
        wait_act(1'b0, 10);
        wr(swr_pkg::LOOPS_OFS, 32'h3);
        for (int s = 0; s < 4; s++) begin
            cfg(1, 0, 0, 0, s, 0);
            hold_chk(32'h0);
            fire(s, 32'h4);
            wait_act(1'b1, 10);
            n = 0;
            for (int i = 0; i < 100 && gc.active === 1'b1; i++) begin
                @(posedge clk);
                n += int'(wend === 1'b1);
            end
            chk(n, 32'h3);
        end
        cfg(1, 0, 0, 0, 0, 0);
        wr(swr_pkg::CMD_OFS, 32'h1);
        far.pin(3);
        hold_chk(32'h0);
        wr(swr_pkg::LOOPS_OFS, 32'h0);
        rdc(swr_pkg::LOOPS_OFS, 32'h1);
        wr(swr_pkg::LOOPS_OFS, 32'hfffff);
        rdc(swr_pkg::LOOPS_OFS, 32'(swr_pkg::LOOPS_MAX));
        wr(swr_pkg::PHASE_OFS, 32'h5a);
        wr(swr_pkg::PHASE_OFS, 32'h168);
        rdc(swr_pkg::PHASE_OFS, 32'h5a);
        for (int w = 0; w < 4; w++) begin
            cfg(w < 3 ? 1 : 0, 0, 0, 0, 2, w % 3);
            repeat (2) @(posedge clk);
            chk(32'(gc.start_phase), w < 2 ? 32'h5a : 32'h0);
        end
        cfg(2, 0, 0, 0, 2, 0);
        hold_chk(32'h0);
        far.pin(5);
        wait_act(1'b1, 10);
        far.pin(6);
        wait_act(1'b0, 10);
        wr(swr_pkg::EXPO_OFS, 32'h80);
        cfg(0, 0, 0, 0, 2, 6);
        repeat (2) @(posedge clk);
        chk(32'(gc.invert), 32'h1);
        wr(swr_pkg::EXPO_OFS, 32'h05);
        repeat (2) @(posedge clk);
        chk(32'(gc.invert), 32'h0);
        cfg(0, 0, 0, 0, 2, 4);
        wait_act(1'b1, 10);
        wr(swr_pkg::SINC_OFS, 32'h6);
        chk(32'(gc.active), 32'h0);
        chk(32'(gc.sinc_cycles), 32'h6);
        wait_act(1'b1, 20);
        wr(swr_pkg::SINC_OFS, 32'h6);
        hold_chk(32'h1);
        cfg(0, 0, 0, 0, 2, 8);
        wait_act(1'b1, 10);
        repeat (4) @(posedge clk);
        for (int i = 0; i < 32; i++) begin
            @(posedge clk);
            smp[i] = noise;
        end
        // a fixed record of 16 samples must repeat exactly
        for (int i = 0; i < 16; i++) chk(32'(smp[i]), 32'(smp[i + 16]));
        chk(32'(smp[0] == smp[1]), 32'h0);
        cfg(0, 0, 0, 0, 2, 0);
        chk(32'(noise), 32'h0);
        finish_test();
    end
endmodule : swr_run_ctrl_test
